// ### verilog/mcr_pkg.sv
`default_nettype none
package mcr_pkg;

  // operand and result widths
  localparam int unsigned OPND_W = 16;
  localparam int unsigned ACC_W  = 32;
  localparam int unsigned MODE_W = 8;
  localparam int unsigned EXT_W  = 9;
  localparam int unsigned IMM_W  = 7;
  localparam int unsigned FLAG_W = 4;
  localparam int unsigned RADR_W = 4;
  localparam int unsigned RDAT_W = 32;
  localparam int unsigned EVT_W  = 2;

  // operating mode values
  localparam logic [MODE_W-1:0] MODE_INIT0  = 8'h00;
  localparam logic [MODE_W-1:0] MODE_INIT1  = 8'h01;
  localparam logic [MODE_W-1:0] MODE_INIT2  = 8'h02;
  localparam logic [MODE_W-1:0] MODE_RD0LO  = 8'h03;
  localparam logic [MODE_W-1:0] MODE_RD0HI  = 8'h13;
  localparam logic [MODE_W-1:0] MODE_RD1LO  = 8'h23;
  localparam logic [MODE_W-1:0] MODE_RD1HI  = 8'h33;
  localparam logic [MODE_W-1:0] MODE_MACU_L = 8'h06;
  localparam logic [MODE_W-1:0] MODE_MACS_L = 8'h07;
  localparam logic [MODE_W-1:0] MODE_MACU_H = 8'h16;
  localparam logic [MODE_W-1:0] MODE_MACS_H = 8'h17;
  localparam logic [MODE_W-1:0] MODE_RESET  = 8'h00;

  // condition flag patterns, order carry overflow zero negative
  localparam logic [FLAG_W-1:0] FLAGS_OVF  = 4'h4;
  localparam logic [FLAG_W-1:0] FLAGS_NONE = 4'h0;

  // register map of the software port
  localparam logic [RADR_W-1:0] ADR_STATUS = 4'h0;
  localparam logic [RADR_W-1:0] ADR_MASK   = 4'h4;
  localparam logic [RADR_W-1:0] ADR_MODE   = 4'h8;
  localparam logic [RADR_W-1:0] ADR_RESULT_REG_ZERO   = 4'hC;

  // status event bits
  localparam int unsigned EVT_OVF  = 0;
  localparam int unsigned EVT_DONE = 1;
  localparam logic [EVT_W-1:0] STATUS_RST = 2'h0;
  localparam logic [EVT_W-1:0] MASK_RST   = 2'h0;
  localparam logic [ACC_W-1:0] RES_RST    = 32'h0000_0000;

  // instruction kinds presented by the core
  typedef enum logic [1:0] {
    MCR_OP_MODE_WR = 2'b00,
    MCR_OP_LOAD    = 2'b01,
    MCR_OP_COMPUTE = 2'b10,
    MCR_OP_NONE    = 2'b11
  } mcr_op_t;

  typedef struct packed {
    logic                    valid;
    mcr_op_t                 op;
    logic [OPND_W-1:0]       rd_val;
    logic [OPND_W-1:0]       rs_val;
    logic                    use_imm;
    logic [EXT_W-1:0]        ext_prefix;
    logic [IMM_W-1:0]        short_immediate_field;
  } mcr_req_t;

  typedef struct packed {
    logic                    valid;
    logic [OPND_W-1:0]       data;
    logic [FLAG_W-1:0]       carry_ovf_zero_neg_flags;
  } mcr_ans_t;

endpackage : mcr_pkg
`default_nettype wire

// ### verilog/mcr_mac_unit.sv
`timescale 1ns/1ns
`default_nettype none
module mcr_mac_unit
  import mcr_pkg::*;
(
  // operands
  input  wire logic [OPND_W-1:0] mul_a_i,
  input  wire logic [OPND_W-1:0] mul_b_i,
  input  wire logic [ACC_W-1:0]  acc_i,
  input  wire logic              signed_i,
  // results
  output logic      [ACC_W-1:0]  sum_o,
  output logic                   ovf_o
);

  logic [ACC_W-1:0] prod;

  always_comb begin
    if (signed_i) begin
      prod = ACC_W'($signed(mul_a_i) * $signed(mul_b_i));
    end else begin
      prod = ACC_W'(mul_a_i * mul_b_i);
    end
    sum_o = prod + acc_i;
    // like signs in, other sign out; unsigned never flags
    ovf_o = signed_i && (prod[ACC_W-1] == acc_i[ACC_W-1])
            && (sum_o[ACC_W-1] != prod[ACC_W-1]);
  end

endmodule : mcr_mac_unit
`default_nettype wire

// ### verilog/mcr_top.sv
// Overview of operation
// - accumulator is product plus previous result zero
// - mode write loads mode, selects behaviour
// - mode 0x00 clears both result registers
// - mode 0x01 load: low half, upper zero
// - mode 0x02 load: first high, second low
// - modes 0x06/0x07 accumulate, return low half
// - modes 0x16/0x17 accumulate, return high half
// - overflow reports flags 0b0100
// - only signed accumulate detects overflow
// - overflow when like signs give other sign
// - result held on an overflowing accumulate
// - clean accumulate, or load/compute outside read modes, clears overflow; mode writes keep it
// - read modes return chosen result half
// - read modes flag zero, registers untouched
// - result registers keep contents until overwritten
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module mcr_top
  import mcr_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // coprocessor instruction port
  input  wire mcr_req_t          req_i,
  output var  mcr_ans_t          ans_o,
  // software register port
  input  wire logic [RADR_W-1:0] reg_addr_i,
  input  wire logic [RDAT_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [RDAT_W-1:0] reg_rdata_o,
  // interrupt
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_mac(input logic [MODE_W-1:0] m);
    is_mac = (m == MODE_MACU_L) || (m == MODE_MACS_L) || (m == MODE_MACU_H) || (m == MODE_MACS_H);
  endfunction : is_mac

  function automatic logic is_read(input logic [MODE_W-1:0] m);
    is_read = (m == MODE_RD0LO) || (m == MODE_RD0HI) || (m == MODE_RD1LO) || (m == MODE_RD1HI);
  endfunction : is_read

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [MODE_W-1:0] mode_r;
  logic [ACC_W-1:0]  result_reg_zero_r;
  logic [ACC_W-1:0]  result_reg_one_r;
  logic              ovf_r;
  mcr_ans_t          ans_r;
  logic [EVT_W-1:0]  sts_r;
  logic [EVT_W-1:0]  sts_nxt;
  logic [EVT_W-1:0]  msk_r;
  logic [EVT_W-1:0]  msk_nxt;
  logic [RDAT_W-1:0] rdata_r;
  logic              irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic [OPND_W-1:0] opnd_b;
  logic              do_mode;
  logic              do_load;
  logic              do_comp;
  logic              mac_comp;
  logic              rd_comp;
  logic [ACC_W-1:0]  mac_sum;
  logic              mac_ovf;
  logic              mac_signed;

  always_comb begin
    if (req_i.use_imm) begin
      opnd_b = {req_i.ext_prefix, req_i.short_immediate_field};
    end else begin
      opnd_b = req_i.rs_val;
    end
  end

  assign do_mode    = req_i.valid && (req_i.op == MCR_OP_MODE_WR);
  assign do_load    = req_i.valid && (req_i.op == MCR_OP_LOAD);
  assign do_comp    = req_i.valid && (req_i.op == MCR_OP_COMPUTE);
  assign mac_comp   = do_comp && is_mac(mode_r);
  assign rd_comp    = do_comp && is_read(mode_r);
  assign mac_signed = (mode_r == MODE_MACS_L) || (mode_r == MODE_MACS_H);

  mcr_mac_unit i_mcr_mac_unit (
    .mul_a_i  (req_i.rd_val),
    .mul_b_i  (opnd_b),
    .acc_i    (result_reg_zero_r),
    .signed_i (mac_signed),
    .sum_o    (mac_sum),
    .ovf_o    (mac_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operating mode

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_RESET;
    end else if (do_mode) begin
      mode_r <= opnd_b[MODE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result registers; untouched by read modes and idle cycles

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      result_reg_zero_r <= RES_RST;
      result_reg_one_r <= RES_RST;
    end else if (do_mode && (opnd_b[MODE_W-1:0] == MODE_INIT0)) begin
      result_reg_zero_r <= RES_RST;
      result_reg_one_r <= RES_RST;
    end else if (do_load && (mode_r == MODE_INIT1)) begin
      result_reg_zero_r <= {{OPND_W{1'b0}}, opnd_b};
    end else if (do_load && (mode_r == MODE_INIT2)) begin
      result_reg_zero_r <= {req_i.rd_val, opnd_b};
    end else if (mac_comp && !mac_ovf) begin
      // an overflowing sum is dropped so the last good value survives
      result_reg_zero_r <= mac_sum;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow flag

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ovf_r <= 1'b0;
    end else if (mac_comp) begin
      ovf_r <= mac_ovf;
    end else if ((do_comp || do_load) && !is_read(mode_r)) begin
      ovf_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer to the core, one cycle after the compute instruction

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ans_r <= '0;
    end else begin
      ans_r.valid <= do_comp;
      if (mac_comp) begin
        if (mac_ovf) begin
          ans_r.carry_ovf_zero_neg_flags <= FLAGS_OVF;
          // held value is returned instead of the lost sum
          ans_r.data <= (mode_r[4]) ? result_reg_zero_r[ACC_W-1:OPND_W] : result_reg_zero_r[OPND_W-1:0];
        end else begin
          ans_r.carry_ovf_zero_neg_flags <= FLAGS_NONE;
          ans_r.data <= (mode_r[4]) ? mac_sum[ACC_W-1:OPND_W] : mac_sum[OPND_W-1:0];
        end
      end else if (rd_comp) begin
        ans_r.carry_ovf_zero_neg_flags <= FLAGS_NONE;
        case (mode_r)
          MODE_RD0LO: ans_r.data <= result_reg_zero_r[OPND_W-1:0];
          MODE_RD0HI: ans_r.data <= result_reg_zero_r[ACC_W-1:OPND_W];
          MODE_RD1LO: ans_r.data <= result_reg_one_r[OPND_W-1:0];
          default:    ans_r.data <= result_reg_one_r[ACC_W-1:OPND_W];
        endcase
      end else if (do_comp) begin
        // compute in an init mode has no defined result
        ans_r.data <= {OPND_W{1'b0}};
        ans_r.carry_ovf_zero_neg_flags <= FLAGS_NONE;
      end
    end
  end

  assign ans_o = ans_r;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear; a new event beats the clear

  always_comb begin
    sts_nxt = sts_r;
    if (reg_wr_i && (reg_addr_i == ADR_STATUS)) begin
      sts_nxt = sts_nxt & ~reg_wdata_i[EVT_W-1:0];
    end
    if (mac_comp && mac_ovf) begin
      sts_nxt[EVT_OVF] = 1'b1;
    end
    if (do_comp) begin
      sts_nxt[EVT_DONE] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sts_r <= STATUS_RST;
    end else begin
      sts_r <= sts_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      msk_r <= MASK_RST;
    end else if (reg_wr_i && (reg_addr_i == ADR_MASK)) begin
      msk_r <= reg_wdata_i[EVT_W-1:0];
    end
  end

  // next mask so the interrupt level never lags a mask write
  always_comb begin
    msk_nxt = msk_r;
    if (reg_wr_i && (reg_addr_i == ADR_MASK)) begin
      msk_nxt = reg_wdata_i[EVT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(sts_nxt & msk_nxt);
    end
  end

  assign irq_o = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data valid the cycle after the strobe

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_r <= {RDAT_W{1'b0}};
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADR_STATUS: rdata_r <= {{(RDAT_W-EVT_W){1'b0}}, sts_r};
        ADR_MASK:   rdata_r <= {{(RDAT_W-EVT_W){1'b0}}, msk_r};
        ADR_MODE:   rdata_r <= {{(RDAT_W-MODE_W-1){1'b0}}, ovf_r, mode_r};
        ADR_RESULT_REG_ZERO:   rdata_r <= result_reg_zero_r;
        default:    rdata_r <= {RDAT_W{1'b0}};
      endcase
    end else begin
      rdata_r <= {RDAT_W{1'b0}};
    end
  end

  assign reg_rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic seen_clean_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      seen_clean_r <= 1'b0;
    end else if (mac_comp && !mac_ovf) begin
      seen_clean_r <= 1'b1;
    end
  end

  AST_MODE_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    do_mode |=> (mode_r == $past(opnd_b[MODE_W-1:0])))
    else $error("mode register did not take written value");

  AST_INIT0_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (do_mode && (opnd_b[MODE_W-1:0] == MODE_INIT0)) |=> (result_reg_zero_r == RES_RST) && (result_reg_one_r == RES_RST))
    else $error("init mode zero did not clear results");

  AST_INIT1_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (do_load && (mode_r == MODE_INIT1)) |=> (result_reg_zero_r == {16'h0000, $past(opnd_b)}))
    else $error("init mode one load wrong");

  AST_INIT2_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (do_load && (mode_r == MODE_INIT2)) |=> (result_reg_zero_r == {$past(req_i.rd_val), $past(opnd_b)}))
    else $error("init mode two load wrong");

  AST_MAC_RESULT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mac_comp && !mac_ovf && !mode_r[4]) |=> ans_o.valid && (ans_o.data == result_reg_zero_r[15:0])
      && (ans_o.carry_ovf_zero_neg_flags == FLAGS_NONE))
    else $error("low half accumulate answer wrong");

  AST_MAC_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mac_comp && !mac_ovf && mode_r[4]) |=> ans_o.valid && (ans_o.data == result_reg_zero_r[31:16])
      && (ans_o.carry_ovf_zero_neg_flags == FLAGS_NONE))
    else $error("high half accumulate answer wrong");

  AST_OVF_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mac_comp && mac_ovf) |=> $stable(result_reg_zero_r) && ovf_r && (ans_o.carry_ovf_zero_neg_flags == FLAGS_OVF))
    else $error("overflow did not hold result or flag");

  AST_UNSIGNED_NO_OVF: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mac_comp && !mac_signed) |=> !ovf_r ##0 ans_o.carry_ovf_zero_neg_flags[2] == 1'b0)
    else $error("unsigned accumulate raised overflow");

  AST_READ_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_comp |=> $stable(result_reg_zero_r) && $stable(result_reg_one_r) && (ans_o.carry_ovf_zero_neg_flags == FLAGS_NONE))
    else $error("read mode disturbed results or flags");

  AST_OVF_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ovf_r && do_load && !is_read(mode_r)) |=> !ovf_r)
    else $error("overflow flag not cleared by load");

  AST_IRQ_LEVEL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    irq_o == (|(sts_r & msk_r)))
    else $error("interrupt level differs from unmasked status");

  AST_ANS_PULSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ans_o.valid == $past(do_comp))
    else $error("answer valid not exactly one cycle after compute");

  AST_RDATA_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !reg_rd_i |=> (reg_rdata_o == {RDAT_W{1'b0}}))
    else $error("read data not zero outside its cycle");

  AST_OVF_CLEAN_CLR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mac_comp && !mac_ovf) |=> !ovf_r && (result_reg_zero_r == $past(mac_sum)))
    else $error("clean accumulate did not clear overflow or store sum");

  AST_LOAD_IGNORED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (do_load && (mode_r != MODE_INIT1) && (mode_r != MODE_INIT2)) |=> $stable(result_reg_zero_r) && $stable(result_reg_one_r))
    else $error("load outside init modes changed results");

  AST_DONE_EVENT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    do_comp |=> sts_r[EVT_DONE])
    else $error("compute did not set done status");

  AST_OVF_EVENT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mac_comp && mac_ovf) |=> sts_r[EVT_OVF])
    else $error("overflow did not set overflow status");

  COV_SIGNED_OVF: cover property (@(posedge sys_clk_i) disable iff (rst_i) mac_comp && mac_ovf);
  COV_OVF_RECOVER: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    ovf_r ##1 (mac_comp && !mac_ovf));
  COV_READ_HIGH1: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_comp && (mode_r == MODE_RD1HI));
  COV_MAC_CHAIN: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    seen_clean_r && mac_comp ##1 mac_comp);

endmodule : mcr_top
`default_nettype wire

// ### tb/mcr_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module mcr_core_model
  import mcr_pkg::*;
(
  // clock
  input  wire logic     sys_clk_i,
  // instruction port
  output var  mcr_req_t req_o,
  input  wire mcr_ans_t ans_i
);
  mcr_ans_t last_ans;

  initial begin
    req_o    = '{1'b0, MCR_OP_NONE, 16'h0000, 16'h0000, 1'b0, 9'h000, 7'h00};
    last_ans = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one valid pulse per instruction, answer taken just after the clock edge that accepts it
  // idle operand lines carry the inverse so a stale operand can never match
  task automatic issue(input mcr_op_t op, input logic [15:0] rd, input logic [15:0] rs,
                       input logic imm, input logic [8:0] ext, input logic [6:0] fld);
    mcr_req_t r;
    r = '{1'b1, op, rd, rs, imm, ext, fld};
    @(posedge sys_clk_i);
    req_o <= r;
    @(posedge sys_clk_i);
    req_o <= '{1'b0, MCR_OP_NONE, ~rd, ~rs, ~imm, ~ext, ~fld};
    #1;
    last_ans = ans_i;
  endtask : issue
endmodule : mcr_core_model
`default_nettype wire

// ### tb/mcr_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module mcr_top_bench
  import mcr_pkg::*;
;
  logic              sys_clk_i;
  logic              rst_i;
  mcr_req_t          req;
  mcr_ans_t          ans;
  logic [RADR_W-1:0] reg_addr;
  logic [RDAT_W-1:0] reg_wdata;
  logic [RDAT_W-1:0] reg_rdata;
  logic              reg_wr;
  logic              reg_rd;
  logic              irq;
  int                bad_count;
  int                checks_done;
  int                cyc;
  logic [31:0]       acc;
  logic [7:0]        rdm [4] = '{MODE_RD0LO, MODE_RD0HI, MODE_RD1LO, MODE_RD1HI};
  logic [15:0]       rdx [4] = '{16'h5678, 16'h1234, 16'h0000, 16'h0000};

  mcr_top i_mcr_top (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .req_i       (req),
    .ans_o       (ans),
    .reg_addr_i  (reg_addr),
    .reg_wdata_i (reg_wdata),
    .reg_wr_i    (reg_wr),
    .reg_rd_i    (reg_rd),
    .reg_rdata_o (reg_rdata),
    .irq_o       (irq)
  );

  mcr_core_model i_mcr_core_model (
    .sys_clk_i (sys_clk_i),
    .req_o     (req),
    .ans_i     (ans)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial sys_clk_i = 1'b0;
  always #10 sys_clk_i = ~sys_clk_i;

  // runaway guard, the full sequence needs well under 1000 cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      $display("[FAIL] %0t run limit reached", $time);
      bad_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // wr=1 writes d, wr=0 reads and expects d one cycle after the strobe
  task automatic rg(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    @(posedge sys_clk_i);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_wdata <= ~d;
    #1;
    if (!wr) chk(reg_rdata, d);
  endtask : rg

  task automatic mode(input logic [7:0] v);
    i_mcr_core_model.issue(MCR_OP_MODE_WR, 16'h0000, {8'h00, v}, 1'b0, 9'h000, 7'h00);
  endtask : mode

  task automatic load(input logic [15:0] a, input logic [15:0] b);
    i_mcr_core_model.issue(MCR_OP_LOAD, a, b, 1'b0, 9'h000, 7'h00);
  endtask : load

  task automatic comp(input logic [15:0] a, input logic [15:0] b, input logic [15:0] d, input logic [3:0] f);
    i_mcr_core_model.issue(MCR_OP_COMPUTE, a, b, 1'b0, 9'h000, 7'h00);
    chk({11'h000, i_mcr_core_model.last_ans}, {11'h000, 1'b1, d, f});
  endtask : comp

  // reference accumulate, wraps at 32 bits like the result register
  function automatic logic [31:0] mac(input logic [31:0] r, input logic [15:0] a, input logic [15:0] b,
                                      input logic sgn);
    logic signed [31:0] p;
    if (sgn)
      p = $signed(a) * $signed(b);
    else
      p = a * b;
    return r + p;
  endfunction : mac

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rg(1'b0, ADR_STATUS, 32'h0000_0000);
    rg(1'b0, ADR_MODE, 32'h0000_0000);
    rg(1'b0, ADR_RESULT_REG_ZERO, 32'h0000_0000);
    rg(1'b1, 4'h2, 32'hFFFF_FFFF);
    rg(1'b0, 4'h2, 32'h0000_0000);
    mode(MODE_INIT2);
    load(16'h1234, 16'h5678);
    rg(1'b0, ADR_RESULT_REG_ZERO, 32'h1234_5678);
    for (int i = 0; i < 4; i++) begin
      mode(rdm[i]);
      comp(16'hAAAA, 16'h5555, rdx[i], FLAGS_NONE);
    end
    rg(1'b0, ADR_RESULT_REG_ZERO, 32'h1234_5678);
    mode(MODE_INIT0);
    rg(1'b0, ADR_RESULT_REG_ZERO, 32'h0000_0000);
    mode(MODE_INIT1);
    i_mcr_core_model.issue(MCR_OP_LOAD, 16'hABCD, 16'hFFFF, 1'b1, 9'h1A5, 7'h3C);
    rg(1'b0, ADR_RESULT_REG_ZERO, {16'h0000, 9'h1A5, 7'h3C});
    // unsigned accumulate wraps without overflow
    mode(MODE_INIT2);
    load(16'hFFFF, 16'hFFFF);
    acc = mac(32'hFFFF_FFFF, 16'hFFFF, 16'hFFFF, 1'b0);
    mode(MODE_MACU_L);
    comp(16'hFFFF, 16'hFFFF, acc[15:0], FLAGS_NONE);
    acc = mac(acc, 16'h0002, 16'h0003, 1'b0);
    mode(MODE_MACU_H);
    comp(16'h0002, 16'h0003, acc[31:16], FLAGS_NONE);
    rg(1'b0, ADR_RESULT_REG_ZERO, acc);
    // signed overflow, held result, status and interrupt
    rg(1'b1, ADR_STATUS, 32'h0000_0003);
    rg(1'b0, ADR_STATUS, 32'h0000_0000);
    rg(1'b1, ADR_MASK, 32'h0000_0001);
    mode(MODE_INIT2);
    load(16'h7FFF, 16'hFFFF);
    mode(MODE_MACS_L);
    comp(16'h0001, 16'h0001, 16'hFFFF, FLAGS_OVF);
    rg(1'b0, ADR_RESULT_REG_ZERO, 32'h7FFF_FFFF);
    rg(1'b0, ADR_STATUS, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    mode(MODE_RD0HI);
    comp(16'h0000, 16'h0000, 16'h7FFF, FLAGS_NONE);
    rg(1'b0, ADR_MODE, 32'h0000_0113);
    mode(MODE_MACS_L);
    comp(16'h0000, 16'h0000, 16'hFFFF, FLAGS_NONE);
    rg(1'b0, ADR_MODE, 32'h0000_0007);
    rg(1'b1, ADR_MASK, 32'h0000_0000);
    rg(1'b0, ADR_MASK, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    rg(1'b1, ADR_STATUS, 32'h0000_0003);
    rg(1'b0, ADR_STATUS, 32'h0000_0000);
    // negative overflow, then a load in accumulate mode clears the flag
    mode(MODE_INIT2);
    load(16'h8000, 16'h0000);
    mode(MODE_MACS_H);
    comp(16'hFFFF, 16'h0001, 16'h8000, FLAGS_OVF);
    load(16'h0000, 16'h0000);
    rg(1'b0, ADR_MODE, 32'h0000_0017);
    acc = mac(32'h8000_0000, 16'hFFFF, 16'hFFFF, 1'b1);
    comp(16'hFFFF, 16'hFFFF, acc[31:16], FLAGS_NONE);
    rg(1'b0, ADR_RESULT_REG_ZERO, acc);
    // same operands unsigned never flag overflow
    mode(MODE_INIT2);
    load(16'h7FFF, 16'hFFFF);
    mode(MODE_MACU_L);
    comp(16'h0001, 16'h0001, 16'h0000, FLAGS_NONE);
    rg(1'b0, ADR_RESULT_REG_ZERO, 32'h8000_0000);
    final_report();
  end
endmodule : mcr_top_bench
`default_nettype wire
